// *** design/roi_window_register_bank.sv ***
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - the bank answers 4-wire writes under page code 05h, reads under 85h, and i2c page 33xxh.
// - bits 0 to 3 at offset 00h enable h area 1, v area 1, h area 2, v area 2, all reset to 0.
// - each 13-bit h start has its low byte at 10h or 18h and bits 12:8 in the next byte.
// - each 13-bit h width has its low byte at 14h or 1Ch and bits 12:8 in the next byte.
// - each 12-bit v start has its low byte at 12h or 1Ah and bits 11:8 in the next byte.
// - each 12-bit v height has its low byte at 16h or 1Eh and bits 11:8 in the next byte.
//
// Purpose: frame-set-zero region-of-interest register bank
// Assumes: serial and i2c decoders sit upstream on core_clk and deliver one-cycle strobes
// Notes:   4-wire access wins when both strobes arrive together; read data one cycle later
//////////////////////////////////////////////////////////////////////////////
module roi_window_register_bank
  import roi_window_pkg::*;
(
  input  wire logic        core_clk,      // 250 MHz core clock
  input  wire logic        rst,           // async reset, active high
  input  wire logic        serStrobe,     // 4-wire access strobe, one cycle
  input  wire logic [7:0]  serPage,       // 4-wire page select code
  input  wire logic [7:0]  serAddr,       // 4-wire register offset
  input  wire logic        i2cStrobe,     // i2c access strobe, one cycle
  input  wire logic        i2cWrite,      // i2c direction, 1 = write
  input  wire logic [15:0] i2cAddr,       // i2c 16-bit register address
  input  wire logic [7:0]  wrData,        // write data for either path
  output logic      [7:0]  rdData,        // read data, registered
  output logic             rdValid,       // read answer pulse
  output logic             hArea1Enable,  // horizontal area 1 enable
  output logic             vArea1Enable,  // vertical area 1 enable
  output logic             hArea2Enable,  // horizontal area 2 enable
  output logic             vArea2Enable,  // vertical area 2 enable
  output logic      [12:0] hStartArea1,   // horizontal start, area 1
  output logic      [11:0] vStartArea1,   // vertical start, area 1
  output logic      [12:0] hWidthArea1,   // horizontal width, area 1
  output logic      [11:0] vHeightArea1,  // vertical height, area 1
  output logic      [12:0] hStartArea2,   // horizontal start, area 2
  output logic      [11:0] vStartArea2,   // vertical start, area 2
  output logic      [12:0] hWidthArea2,   // horizontal width, area 2
  output logic      [11:0] vHeightArea2   // vertical height, area 2
);

  //////////////////////////////////////////////////////////////////////////////
  // access decode

  logic        serWrHit;
  logic        serRdHit;
  logic        i2cHit;
  logic        wrHit;
  logic        rdHit;
  logic [7:0]  offs;
  logic        enWr;
  logic        fieldWr;
  logic [7:0]  enables_reg;
  logic [7:0]  fieldBytes [16];
  logic [12:0] fieldVal [FIELD_COUNT];
  logic [FIELD_COUNT-1:0] fieldPend;
  logic [7:0]  rdByte;
  logic [7:0]  rdData_reg;
  logic        rdValid_reg;

  assign serWrHit = serStrobe && (serPage == PAGE_WRITE_CODE);
  assign serRdHit = serStrobe && (serPage == PAGE_READ_CODE);
  assign i2cHit   = i2cStrobe && !serStrobe && (i2cAddr[15:8] == I2C_PAGE_CODE);
  assign wrHit    = serWrHit || (i2cHit && i2cWrite);
  assign rdHit    = serRdHit || (i2cHit && !i2cWrite);
  assign offs     = serStrobe ? serAddr : i2cAddr[7:0];
  assign enWr     = wrHit && (offs == ROI_AREA_ENABLES_OFFSET);
  // field bytes occupy one 16-byte block, low byte at even offset
  assign fieldWr  = wrHit && (offs[7:4] == H_START1_LOW_OFFSET[7:4]);

  //////////////////////////////////////////////////////////////////////////////
  // enable register

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      enables_reg <= ENABLES_RESET;
    end else if (enWr) begin
      enables_reg <= wrData & ENABLE_MASK;
    end
  end

  assign hArea1Enable = enables_reg[0];
  assign vArea1Enable = enables_reg[1];
  assign hArea2Enable = enables_reg[2];
  assign vArea2Enable = enables_reg[3];

  //////////////////////////////////////////////////////////////////////////////
  // split fields: even index horizontal (13 bit), odd index vertical (12 bit)

  for (genvar i = 0; i < FIELD_COUNT; i++) begin : gField
    localparam logic [2:0] IDX = 3'(i);
    roi_field_pair #(
      .HIGH_MASK ((i % 2 == 0) ? H_HIGH_MASK : V_HIGH_MASK)
    ) uPair (
      .core_clk   (core_clk),
      .rst        (rst),
      .wrLow      (fieldWr && (offs[3:0] == {IDX, 1'b0})),
      .wrHigh     (fieldWr && (offs[3:0] == {IDX, 1'b1})),
      .wrData     (wrData),
      .lowByte    (fieldBytes[2*i]),
      .highByte   (fieldBytes[2*i+1]),
      .pending    (fieldPend[i]),
      .fieldValue (fieldVal[i])
    );
  end

  assign hStartArea1  = fieldVal[0];
  assign vStartArea1  = fieldVal[1][11:0];
  assign hWidthArea1  = fieldVal[2];
  assign vHeightArea1 = fieldVal[3][11:0];
  assign hStartArea2  = fieldVal[4];
  assign vStartArea2  = fieldVal[5][11:0];
  assign hWidthArea2  = fieldVal[6];
  assign vHeightArea2 = fieldVal[7][11:0];

  //////////////////////////////////////////////////////////////////////////////
  // read path

  // unmapped offsets in the page answer zero rather than stalling the host
  assign rdByte = (offs == ROI_AREA_ENABLES_OFFSET) ? enables_reg :
                  (offs[7:4] == H_START1_LOW_OFFSET[7:4]) ? fieldBytes[offs[3:0]] :
                  UNMAPPED_READ;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdData_reg  <= BYTE_RESET;
      rdValid_reg <= 1'b0;
    end else begin
      rdValid_reg <= rdHit;
      if (rdHit) begin
        rdData_reg <= rdByte;
      end
    end
  end

  assign rdData  = rdData_reg;
  assign rdValid = rdValid_reg;

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  // helper: writes through the 4-wire path only
  logic serWr10;
  logic serWr11;
  logic serWr1e;
  assign serWr10 = serWrHit && (serAddr == H_START1_LOW_OFFSET);
  assign serWr11 = serWrHit && (serAddr == H_START1_HIGH_OFFSET);
  assign serWr1e = serWrHit && (serAddr == V_HEIGHT2_LOW_OFFSET);

  property p_writeCodeOnly;
    @(posedge core_clk) disable iff (rst)
    (serStrobe && serPage == PAGE_READ_CODE && serAddr == ROI_AREA_ENABLES_OFFSET)
      |=> $stable(enables_reg) and rdValid;
  endproperty
  a_writeCodeOnly: assert property (p_writeCodeOnly)
    else $error("read page code altered the enables or gave no answer");

  property p_otherPageIgnored;
    @(posedge core_clk) disable iff (rst)
    (serStrobe && serPage != PAGE_READ_CODE && serPage != PAGE_WRITE_CODE)
      |=> !rdValid && $stable(enables_reg);
  endproperty
  a_otherPageIgnored: assert property (p_otherPageIgnored)
    else $error("access to another page was answered");

  property p_i2cEnable;
    @(posedge core_clk) disable iff (rst)
    (i2cStrobe && !serStrobe && i2cWrite && i2cAddr == {I2C_PAGE_CODE, 8'h00})
      |=> {vArea2Enable, hArea2Enable, vArea1Enable, hArea1Enable} == $past(wrData[3:0]);
  endproperty
  a_i2cEnable: assert property (p_i2cEnable)
    else $error("i2c write to enables not applied in bit order");

  property p_enableHold;
    @(posedge core_clk) disable iff (rst)
    !enWr |=> $stable({vArea2Enable, hArea2Enable, vArea1Enable, hArea1Enable});
  endproperty
  a_enableHold: assert property (p_enableHold)
    else $error("enable bit moved without a write");

  property p_hStartPair;
    @(posedge core_clk) disable iff (rst)
    (serWr10 && !fieldPend[0]) ##1 serWr11
      |=> hStartArea1 == {$past(wrData[4:0]), $past(wrData, 2)};
  endproperty
  a_hStartPair: assert property (p_hStartPair)
    else $error("h start area 1 not assembled from its two bytes");

  property p_hStartReadHigh;
    @(posedge core_clk) disable iff (rst)
    (serRdHit && serAddr == H_START1_HIGH_OFFSET) |=> rdValid && rdData[7:5] == 3'h0;
  endproperty
  a_hStartReadHigh: assert property (p_hStartReadHigh)
    else $error("h start high byte shows upper bits");

  property p_hWidthHold;
    @(posedge core_clk) disable iff (rst)
    $changed(hWidthArea2) |-> $past(fieldWr && offs[3:1] == 3'h6);
  endproperty
  a_hWidthHold: assert property (p_hWidthHold)
    else $error("h width area 2 changed without a write to its bytes");

  property p_vStartTop;
    @(posedge core_clk) disable iff (rst)
    $changed(vStartArea1) |-> $past(fieldWr && offs[3:1] == 3'h1);
  endproperty
  a_vStartTop: assert property (p_vStartTop)
    else $error("v start area 1 changed without a write to its bytes");

  property p_vHeightPair;
    @(posedge core_clk) disable iff (rst)
    (serWr1e && !fieldPend[7]) ##1 (serWrHit && serAddr == V_HEIGHT2_HIGH_OFFSET)
      |=> vHeightArea2 == {$past(wrData[3:0]), $past(wrData, 2)};
  endproperty
  a_vHeightPair: assert property (p_vHeightPair)
    else $error("v height area 2 not assembled from its two bytes");

  property p_resetZero;
    @(posedge core_clk)
    $fell(rst) |-> enables_reg == ENABLES_RESET && hStartArea1 == FIELD_RESET
                   && vHeightArea2 == 12'h000 && !rdValid;
  endproperty
  a_resetZero: assert property (p_resetZero)
    else $error("bank not cleared by reset");

  property p_lowAloneHolds;
    @(posedge core_clk) disable iff (rst)
    (serWr10 && !fieldPend[0]) |=> $stable(hStartArea1)
      ##1 ($stable(hStartArea1) || $past(wrHit && offs == H_START1_HIGH_OFFSET));
  endproperty
  a_lowAloneHolds: assert property (p_lowAloneHolds)
    else $error("h start applied after only its low byte");

  property p_i2cReadAnswer;
    @(posedge core_clk) disable iff (rst)
    (i2cHit && !i2cWrite) |=> rdValid;
  endproperty
  a_i2cReadAnswer: assert property (p_i2cReadAnswer)
    else $error("i2c read of the page gave no answer");

  property p_i2cOtherPage;
    @(posedge core_clk) disable iff (rst)
    (i2cStrobe && !serStrobe && i2cAddr[15:8] != I2C_PAGE_CODE)
      |=> !rdValid && $stable(enables_reg) && $stable(fieldPend);
  endproperty
  a_i2cOtherPage: assert property (p_i2cOtherPage)
    else $error("access to another i2c page had an effect");

  property p_unmappedRead;
    @(posedge core_clk) disable iff (rst)
    (rdHit && offs != ROI_AREA_ENABLES_OFFSET && offs[7:4] != H_START1_LOW_OFFSET[7:4])
      |=> rdValid && rdData == UNMAPPED_READ;
  endproperty
  a_unmappedRead: assert property (p_unmappedRead)
    else $error("unmapped offset did not read zero");

  property p_enableReadUpper;
    @(posedge core_clk) disable iff (rst)
    (rdHit && offs == ROI_AREA_ENABLES_OFFSET) |=> rdValid && rdData[7:4] == 4'h0;
  endproperty
  a_enableReadUpper: assert property (p_enableReadUpper)
    else $error("enable byte shows upper bits");

  property p_hWidthReadHigh;
    @(posedge core_clk) disable iff (rst)
    (rdHit && offs == H_WIDTH2_HIGH_OFFSET) |=> rdValid && rdData[7:5] == 3'h0;
  endproperty
  a_hWidthReadHigh: assert property (p_hWidthReadHigh)
    else $error("h width high byte shows upper bits");

  property p_vStartReadHigh;
    @(posedge core_clk) disable iff (rst)
    (rdHit && offs == V_START1_HIGH_OFFSET) |=> rdValid && rdData[7:4] == 4'h0;
  endproperty
  a_vStartReadHigh: assert property (p_vStartReadHigh)
    else $error("v start high byte shows upper bits");

  property p_vHeightReadHigh;
    @(posedge core_clk) disable iff (rst)
    (rdHit && offs == V_HEIGHT1_HIGH_OFFSET) |=> rdValid && rdData[7:4] == 4'h0;
  endproperty
  a_vHeightReadHigh: assert property (p_vHeightReadHigh)
    else $error("v height high byte shows upper bits");

  property p_hStart2Hold;
    @(posedge core_clk) disable iff (rst)
    $changed(hStartArea2) |-> $past(fieldWr && offs[3:1] == 3'h4);
  endproperty
  a_hStart2Hold: assert property (p_hStart2Hold)
    else $error("h start area 2 changed without a write to its bytes");

  cover property (@(posedge core_clk) disable iff (rst) serWr10 ##1 serWr11);
  cover property (@(posedge core_clk) disable iff (rst) i2cHit && !i2cWrite);
  cover property (@(posedge core_clk) disable iff (rst) enWr ##1 hArea2Enable);
  cover property (@(posedge core_clk) disable iff (rst) serStrobe && i2cStrobe);

endmodule

// *** design/roi_window_pkg.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: constants for the frame-set-zero region-of-interest register bank
// Assumes: byte-wide registers, one page of the sensor control space
// Notes:   page codes, offsets, field layouts and reset values live here
//////////////////////////////////////////////////////////////////////////////
package roi_window_pkg;

  // page select codes on the 4-wire port and the i2c page
  localparam logic [7:0] PAGE_WRITE_CODE = 8'h05;
  localparam logic [7:0] PAGE_READ_CODE  = 8'h85;
  localparam logic [7:0] I2C_PAGE_CODE   = 8'h33;

  // register offsets within the page
  localparam logic [7:0] ROI_AREA_ENABLES_OFFSET = 8'h00;
  localparam logic [7:0] H_START1_LOW_OFFSET     = 8'h10;
  localparam logic [7:0] H_START1_HIGH_OFFSET    = 8'h11;
  localparam logic [7:0] V_START1_LOW_OFFSET     = 8'h12;
  localparam logic [7:0] V_START1_HIGH_OFFSET    = 8'h13;
  localparam logic [7:0] H_WIDTH1_LOW_OFFSET     = 8'h14;
  localparam logic [7:0] H_WIDTH1_HIGH_OFFSET    = 8'h15;
  localparam logic [7:0] V_HEIGHT1_LOW_OFFSET    = 8'h16;
  localparam logic [7:0] V_HEIGHT1_HIGH_OFFSET   = 8'h17;
  localparam logic [7:0] H_START2_LOW_OFFSET     = 8'h18;
  localparam logic [7:0] H_START2_HIGH_OFFSET    = 8'h19;
  localparam logic [7:0] V_START2_LOW_OFFSET     = 8'h1a;
  localparam logic [7:0] V_START2_HIGH_OFFSET    = 8'h1b;
  localparam logic [7:0] H_WIDTH2_LOW_OFFSET     = 8'h1c;
  localparam logic [7:0] H_WIDTH2_HIGH_OFFSET    = 8'h1d;
  localparam logic [7:0] V_HEIGHT2_LOW_OFFSET    = 8'h1e;
  localparam logic [7:0] V_HEIGHT2_HIGH_OFFSET   = 8'h1f;

  // field layout: enable bits and high-byte masks
  localparam int         ENABLE_BITS      = 4;
  localparam logic [7:0] ENABLE_MASK      = 8'h0f;
  localparam int         FIELD_COUNT      = 8;
  localparam int         H_FIELD_BITS     = 13;
  localparam int         V_FIELD_BITS     = 12;
  localparam logic [7:0] H_HIGH_MASK      = 8'h1f;
  localparam logic [7:0] V_HIGH_MASK      = 8'h0f;

  // reset values
  localparam logic [7:0]  ENABLES_RESET   = 8'h00;
  localparam logic [7:0]  BYTE_RESET      = 8'h00;
  localparam logic [12:0] FIELD_RESET     = 13'h0000;
  localparam logic [7:0]  UNMAPPED_READ   = 8'h00;

endpackage

// *** design/roi_field_pair.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: one split field held as a low and a high byte plus applied value
// Assumes: at most one of the two byte writes in a cycle
// Notes:   applied value moves only once both bytes were rewritten
//////////////////////////////////////////////////////////////////////////////
module roi_field_pair
  import roi_window_pkg::*;
#(
  parameter logic [7:0] HIGH_MASK = 8'h1f
) (
  input  wire logic        core_clk,   // core clock
  input  wire logic        rst,        // async reset, active high
  input  wire logic        wrLow,      // write strobe, low byte
  input  wire logic        wrHigh,     // write strobe, high byte
  input  wire logic [7:0]  wrData,     // write data
  output logic      [7:0]  lowByte,    // stored low byte
  output logic      [7:0]  highByte,   // stored high byte, masked
  output logic             pending,    // one byte written, other awaited
  output logic      [12:0] fieldValue  // applied value
);

  logic        lowPend_reg;
  logic        highPend_reg;
  logic [7:0]  low_reg;
  logic [7:0]  high_reg;
  logic [12:0] value_reg;
  logic        lowSeen;
  logic        highSeen;
  logic        commit;
  logic [7:0]  low_next;
  logic [7:0]  high_next;

  // unused upper bits never get stored, so they read back zero
  assign low_next  = wrLow  ? wrData : low_reg;
  assign high_next = wrHigh ? (wrData & HIGH_MASK) : high_reg;
  assign lowSeen   = lowPend_reg | wrLow;
  assign highSeen  = highPend_reg | wrHigh;
  assign commit    = lowSeen & highSeen;

  // byte storage and pairing flags
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      low_reg      <= BYTE_RESET;
      high_reg     <= BYTE_RESET;
      lowPend_reg  <= 1'b0;
      highPend_reg <= 1'b0;
    end else begin
      low_reg      <= low_next;
      high_reg     <= high_next;
      lowPend_reg  <= lowSeen & ~commit;
      highPend_reg <= highSeen & ~commit;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      value_reg <= FIELD_RESET;
    end else if (commit) begin
      value_reg <= {high_next[4:0], low_next};
    end
  end

  assign lowByte    = low_reg;
  assign highByte   = high_reg;
  assign pending    = lowPend_reg | highPend_reg;
  assign fieldValue = value_reg;

endmodule

// *** sim/roi_host_model.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: host controller model on the bank's 4-wire and i2c strobes
// Assumes: tasks are entered just after a rising edge of core_clk
// Notes:   released qualifier and data lines show the inverse of the last value; strobes drop to zero
//////////////////////////////////////////////////////////////////////////////
module roi_host_model
  import roi_window_pkg::*;
(
  input  wire logic        core_clk,   // core clock
  output logic             serStrobe,  // 4-wire access strobe
  output logic      [7:0]  serPage,    // page select code
  output logic      [7:0]  serAddr,    // register offset
  output logic             i2cStrobe,  // i2c access strobe
  output logic             i2cWrite,   // i2c direction
  output logic      [15:0] i2cAddr,    // i2c address
  output logic      [7:0]  wrData      // write data
);
  timeunit 1ns;
  timeprecision 1ps;

  // quiet bus at time zero
  initial begin
    {serStrobe, serPage, serAddr, i2cStrobe, i2cWrite, i2cAddr, wrData} = '0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // one access, page code and every line set by the caller
  task automatic access(input logic s, input logic [7:0] pg, input logic [7:0] ad,
                        input logic i, input logic iw, input logic [15:0] ia,
                        input logic [7:0] d);
    serStrobe <= s;
    serPage   <= pg;
    serAddr   <= ad;
    i2cStrobe <= i;
    i2cWrite  <= iw;
    i2cAddr   <= ia;
    wrData    <= d;
    @(posedge core_clk);
  endtask

  // release: scrambled qualifiers so a stale value cannot pass for a live one
  task automatic idle();
    serStrobe <= 1'b0;
    i2cStrobe <= 1'b0;
    serPage   <= ~serPage;
    serAddr   <= ~serAddr;
    i2cWrite  <= ~i2cWrite;
    i2cAddr   <= ~i2cAddr;
    wrData    <= ~wrData;
    @(posedge core_clk);
  endtask

  function automatic logic [7:0] legal(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h00) return d & ENABLE_MASK;
    if (a[7:4] != 4'h1) return d;
    if (!a[0]) return d & 8'hfc;
    return d & (a[1] ? V_HIGH_MASK : H_HIGH_MASK);
  endfunction
endmodule

// *** sim/roi_window_register_bank_test.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: self-checking bench for the region-of-interest register bank
// Assumes: host model drives, reads answered one cycle after the strobe
// Notes:   expected bytes and applied fields are kept in a shadow model
//////////////////////////////////////////////////////////////////////////////
module roi_window_register_bank_test
  import roi_window_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk, rst, serStrobe, i2cStrobe, i2cWrite, rdValid;
  logic [7:0]  serPage, serAddr, wrData, rdData, a;
  logic [15:0] i2cAddr, r;
  wire  [3:0]  en;
  wire  [12:0] hs1, hw1, hs2, hw2;
  wire  [11:0] vs1, vh1, vs2, vh2;
  logic [7:0]  shadow [32];
  logic [12:0] applied [8];
  logic [1:0]  half [8];
  logic [7:0]  expQ [$];
  int          errors, n_compared;

  roi_host_model host (.core_clk(core_clk), .serStrobe(serStrobe), .serPage(serPage),
    .serAddr(serAddr), .i2cStrobe(i2cStrobe), .i2cWrite(i2cWrite), .i2cAddr(i2cAddr),
    .wrData(wrData));
  roi_window_register_bank dut (.core_clk(core_clk), .rst(rst), .serStrobe(serStrobe),
    .serPage(serPage), .serAddr(serAddr), .i2cStrobe(i2cStrobe), .i2cWrite(i2cWrite),
    .i2cAddr(i2cAddr), .wrData(wrData), .rdData(rdData), .rdValid(rdValid),
    .hArea1Enable(en[0]), .vArea1Enable(en[1]), .hArea2Enable(en[2]), .vArea2Enable(en[3]),
    .hStartArea1(hs1), .vStartArea1(vs1), .hWidthArea1(hw1), .vHeightArea1(vh1),
    .hStartArea2(hs2), .vStartArea2(vs2), .hWidthArea2(hw2), .vHeightArea2(vh2));

  // 4 ns clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // shadow cleared as a reset would
  function automatic void clearModel();
    foreach (shadow[i]) shadow[i] = BYTE_RESET;
    foreach (applied[i]) applied[i] = FIELD_RESET;
    foreach (half[i]) half[i] = 2'b00;
  endfunction

  // stored enable and high bytes are masked; a field applies once both bytes were rewritten
  function automatic void noteWrite(input logic [7:0] ad, input logic [7:0] dt);
    int f;
    f = ad[3:1];
    if (ad == 8'h00) shadow[0] = dt & ENABLE_MASK;
    else if (ad[7:4] == 4'h1) begin
      shadow[ad[4:0]] = ad[0] ? dt & (ad[1] ? V_HIGH_MASK : H_HIGH_MASK) : dt;
      half[f][ad[0]] = 1'b1;
      if (half[f] == 2'b11) begin
        applied[f] = {shadow[{ad[4:1], 1'b1}][4:0], shadow[{ad[4:1], 1'b0}]};
        half[f] = 2'b00;
      end
    end
  endfunction

  function automatic logic [7:0] expRead(input logic [7:0] ad);
    return (ad == 8'h00 || ad[7:4] == 4'h1) ? shadow[ad[4:0]] : UNMAPPED_READ;
  endfunction

  task automatic check(input logic [12:0] seen, input logic [12:0] want);
    n_compared++;
    if (seen !== want) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // path 0 = 4-wire, 1 = i2c; reads leave their answer in the queue
  task automatic hostAccess(input bit path, input bit wr, input logic [7:0] ad,
                            input logic [7:0] dt);
    if (wr) noteWrite(ad, dt);
    else expQ.push_back(expRead(ad));
    host.access(!path, wr ? PAGE_WRITE_CODE : PAGE_READ_CODE, ad, path, wr,
                {I2C_PAGE_CODE, ad}, dt);
  endtask

  // compares every field and enable output mid-cycle, then realigns to the edge
  task automatic checkFields();
    logic [12:0] got [8];
    #1;
    got = '{hs1, {1'b0, vs1}, hw1, {1'b0, vh1}, hs2, {1'b0, vs2}, hw2, {1'b0, vh2}};
    for (int i = 0; i < 8; i++) check(got[i], applied[i]);
    check({9'h000, en}, {5'h00, shadow[0]});
    @(posedge core_clk);
  endtask

  task automatic complete_run();
    if (errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // answers are matched against the oldest noted read
  always @(negedge core_clk) begin
    if (rdValid === 1'b1) begin
      if (expQ.size() == 0) check({12'h000, rdValid}, 13'h0000);
      else check({5'h00, rdData}, {5'h00, expQ.pop_front()});
    end
  end

  // watchdog, far beyond the roughly 310 cycles the sequence needs
  initial begin
    #40000;
    errors++;
    complete_run();
  end

  initial begin
    errors = 0;
    n_compared = 0;
    r = 16'hd3d2;
    rst = 1'b1;
    clearModel();
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    // reset values read back to back, unmapped offsets included
    for (int i = 0; i < 34; i++) hostAccess(i[0], 1'b0, i[7:0], 8'h00);
    host.idle();
    checkFields();
    // random single-byte writes over either path
    repeat (60) begin
      r = lfsr(r);
      a = 8'h10 | {4'h0, r[3:0]};
      hostAccess(r[4], 1'b1, a, host.legal(a, r[15:8]));
      host.idle();
      checkFields();
    end
    // both bytes back to back, high byte first, then read all back
    for (int f = 0; f < 8; f++) begin
      r = lfsr(r);
      hostAccess(r[0], 1'b1, 8'(8'h11 + 2 * f), host.legal(8'(8'h11 + 2 * f), r[15:8]));
      hostAccess(r[1], 1'b1, 8'(8'h10 + 2 * f), host.legal(8'(8'h10 + 2 * f), r[7:0]));
    end
    for (int i = 0; i < 32; i++) hostAccess(i[1], 1'b0, i[7:0], 8'h00);
    host.idle();
    checkFields();
    // each enable alone, then upper bits set against the host's duty
    for (int i = 0; i < 5; i++) begin
      hostAccess(1'b1, 1'b1, 8'h00, i < 4 ? 8'(1 << i) : 8'hff);
      host.idle();
      checkFields();
    end
    hostAccess(1'b0, 1'b1, 8'h13, 8'hff);
    hostAccess(1'b1, 1'b0, 8'h13, 8'h00);
    // foreign pages, a dropped i2c collision, an unmapped write
    host.access(1'b1, 8'h06, 8'h10, 1'b0, 1'b0, 16'h0000, 8'h55);
    host.access(1'b1, 8'h86, 8'h10, 1'b0, 1'b0, 16'h0000, 8'h00);
    host.access(1'b0, 8'h05, 8'h10, 1'b1, 1'b1, 16'h3410, 8'h55);
    noteWrite(8'h12, 8'h40);
    host.access(1'b1, PAGE_WRITE_CODE, 8'h12, 1'b1, 1'b1, 16'h3314, 8'h40);
    hostAccess(1'b0, 1'b1, 8'h20, 8'hff);
    for (int i = 16; i < 22; i++) hostAccess(i[0], 1'b0, i[7:0], 8'h00);
    hostAccess(1'b1, 1'b0, 8'h20, 8'h00);
    // mid-run reset drops a half-written pair
    hostAccess(1'b0, 1'b1, 8'h18, 8'h24);
    host.idle();
    rst <= 1'b1;
    clearModel();
    checkFields();
    rst <= 1'b0;
    hostAccess(1'b0, 1'b1, 8'h19, 8'h03);
    hostAccess(1'b1, 1'b0, 8'h18, 8'h00);
    // fresh pairs low byte first over the 4-wire path
    hostAccess(1'b0, 1'b1, 8'h10, 8'h24);
    hostAccess(1'b0, 1'b1, 8'h11, 8'h15);
    hostAccess(1'b0, 1'b1, 8'h1e, 8'h38);
    hostAccess(1'b0, 1'b1, 8'h1f, 8'h0a);
    host.idle();
    checkFields();
    repeat (2) @(posedge core_clk);
    check(13'(expQ.size()), 13'h0000);
    complete_run();
  end
endmodule
